// ==== hdl/cmfs_pkg.sv ====
// What this block does
// - chain starts on a clean key press only while idle processor and no tape transfer
// - chain has two time states, each ended by a pulse; last may start a cycle
// - first pulse sets state one; each ~2 us delay gives the next pulse
// - key-held level rises with first pulse and stays while the key is down
// - third pulse sets active and cycle-complete for every key but initialisation
// - all keys but resume clear skip, word-half and major states at first pulse
// - initialisation at second pulse clears processor state and peripheral controllers
// - initialisation third pulse sets mode from switch and forces low field bits
// - power-on clear does the same but always picks basic mode
// - initialisation keeps opcode register but forces its top three bits to one
// - deposit/inspect third pulse loads left switches to address, starts memory, no next-instruction
// - time pulse 2 clears opcode register unless defer, execute or second-execute set
// - state 3 loads right switches (deposit) or memory word (inspect) into buffer
// - state 5 of deposit/inspect clears active and auto-repeat
// - deposit-advance sets own flag, auto-repeat if held, reloads address, writes switches
// - after deposit-advance and release, inspect-advance runs with address carry insert
// - inspect-advance increments address at pulse 1, reads memory, clears flags at 5
// - start-20 loads 20 into counter at second pulse, copies to address, fetch, active
// - start-400 acts like start-20 but begins at 400
// - start-switches loads left switches to counter and field bits from switches 00-01
// - with extended memory, field switches go to instruction buffer high bits
// - a processor cycle begins only when active, cycle-complete and memory idle
//
// package of the console manual sequencer: constants, key and output carriers.
// assumes a 10 MHz clock and msb-first bit numbering of 12-bit words.
package cmfs_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int STEP_DELAY_NS = 2000;                    // manual chain step, about 2 us
    localparam int STEP_DELAY_CYC = STEP_DELAY_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 5;

    // ************************************************************
    // data values and field presets (bit 0 is the msb)
    // ************************************************************
    localparam int WORD_W = 12;
    localparam int FIELD_W = 6;
    localparam int SAVE_W = 7;
    localparam logic [11:0] START20_ADDR = 12'h010;         // bit 07 set, octal 20
    localparam logic [11:0] START400_ADDR = 12'h100;        // bit 03 set, octal 400
    localparam logic [2:0] OPC_TOP_FORCE = 3'h7;            // opcode bits 0..2
    localparam logic [5:0] INSTR_FIELD_PRESET = 6'h04;      // bit 03
    localparam logic [5:0] DATA_FIELD_PRESET = 6'h06;       // bits 03 and 04
    localparam logic [6:0] SAVE_FIELD_PRESET = 7'h01;       // bit 06
    localparam logic MODE_BASIC = 1'b0;
    localparam logic [11:0] WORD_RESET = 12'h000;

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic init_key;
        logic deposit_key;
        logic inspect_key;
        logic deposit_advance_key;
        logic inspect_advance_key;
        logic start20_key;
        logic start400_key;
        logic begin_from_switches_key;
        logic resume_key;
    } cmfs_keys_t;

    typedef struct packed {
        logic key_held_level;
        logic manual_pulse_first;
        logic manual_pulse_second;
        logic manual_pulse_third;
        logic manual_state_first;
        logic manual_state_second;
    } cmfs_chain_t;

    typedef struct packed {
        logic skip_clear;
        logic half_clear;
        logic major_clear;
        logic cpu_clear;
        logic periph_clear;
    } cmfs_clears_t;

    typedef enum logic [3:0] {
        OP_NONE, OP_INIT, OP_DEP, OP_INSP, OP_DEPADV,
        OP_INSPADV, OP_ST20, OP_ST400, OP_STSW, OP_RESUME
    } cmfs_op_t;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_S1   = 2'b01,
        CH_S2   = 2'b11,
        CH_WAIT = 2'b10
    } cmfs_chain_st_t;

endpackage : cmfs_pkg

// ==== hdl/cmfs_sync.sv ====
// two-flop synchroniser for the operator pins.
// assumes the pins are asynchronous levels; nothing reads the first stage but the second.
`timescale 1ns/100ps
module cmfs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ************************************************************
    // two stages
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : cmfs_sync

// ==== hdl/cmfs_sequencer.sv ====
// console manual function sequencer: key chain, manual ops and cycle hand-off.
// assumes processor time pulses, major states and memory data arrive on clk.
`timescale 1ns/100ps
module cmfs_sequencer (
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire cmfs_pkg::cmfs_keys_t keys,
    input  wire logic [11:0]         left_switch_bank,
    input  wire logic [11:0]         right_switch_bank,
    input  wire logic [2:0]          field_switches,
    input  wire logic                mode_switch,
    input  wire logic                auto_switch,
    input  wire logic                ext_mem_fitted,
    input  wire logic                tape_busy,
    input  wire logic                power_clear,
    input  wire logic                tp1,
    input  wire logic                tp2,
    input  wire logic                tp3,
    input  wire logic                tp5,
    input  wire logic                mem_idle,
    input  wire logic                defer_state,
    input  wire logic                execute_state,
    input  wire logic                execute2_state,
    input  wire logic [11:0]         mem_data,
    output cmfs_pkg::cmfs_chain_t    chain,
    output cmfs_pkg::cmfs_clears_t   clears,
    output logic                     active,
    output logic                     cycle_done,
    output logic                     cycle_start,
    output logic                     next_instr_gate,
    output logic                     fetch_set,
    output logic                     mem_write,
    output logic                     auto_repeat,
    output logic                     deposit_adv_flag,
    output logic                     inspect_adv_flag,
    output logic                     mode_reg,
    output logic [11:0]              mem_addr_reg,
    output logic [11:0]              memory_buffer_reg,
    output logic [11:0]              opcode_holding_reg,
    output logic [11:0]              prog_counter,
    output logic [5:0]               instr_buffer_field,
    output logic [5:0]               instr_field_reg,
    output logic [5:0]               data_field_reg,
    output logic [6:0]               save_field_reg
);

    localparam logic [cmfs_pkg::TIMER_W-1:0] STEP_CYC = cmfs_pkg::TIMER_W'(cmfs_pkg::STEP_DELAY_CYC);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int SYNC_W = 9 + 12 + 12 + 3 + 5;
    logic [SYNC_W-1:0]    sync_q;
    cmfs_pkg::cmfs_keys_t keys_s;
    logic [11:0]          lsw_s;
    logic [11:0]          rsw_s;
    logic [2:0]           fsw_s;
    logic                 mode_s;
    logic                 auto_s;
    logic                 ext_s;
    logic                 tape_s;
    logic                 pwr_s;

    cmfs_sync #(.W(SYNC_W)) u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({keys, left_switch_bank, right_switch_bank, field_switches,
                 mode_switch, auto_switch, ext_mem_fitted, tape_busy, power_clear}),
        .q     (sync_q)
    );

    assign {keys_s, lsw_s, rsw_s, fsw_s, mode_s, auto_s, ext_s, tape_s, pwr_s} = sync_q;

    // ************************************************************
    // key decode and start condition
    // ************************************************************
    cmfs_pkg::cmfs_chain_st_t st_r;
    cmfs_pkg::cmfs_op_t       op_r;
    cmfs_pkg::cmfs_op_t       key_op;
    logic [cmfs_pkg::TIMER_W-1:0] tmr_r;
    logic key_any;
    logic armed_r;
    logic pwr_d_r;
    logic pwr_rise;
    logic pwr_op_r;
    logic start;
    logic step_done;
    logic p0;
    logic p1;
    logic p2;
    logic manual_r;
    logic carry_ins_r;

    // one key at a time is assumed; priority only breaks accidental overlaps
    always_comb begin
        key_op = cmfs_pkg::OP_NONE;
        if (keys_s.init_key)                     key_op = cmfs_pkg::OP_INIT;
        else if (keys_s.deposit_key)             key_op = cmfs_pkg::OP_DEP;
        else if (keys_s.inspect_key)             key_op = cmfs_pkg::OP_INSP;
        else if (keys_s.deposit_advance_key)     key_op = cmfs_pkg::OP_DEPADV;
        else if (keys_s.inspect_advance_key)     key_op = cmfs_pkg::OP_INSPADV;
        else if (keys_s.start20_key)             key_op = cmfs_pkg::OP_ST20;
        else if (keys_s.start400_key)            key_op = cmfs_pkg::OP_ST400;
        else if (keys_s.begin_from_switches_key) key_op = cmfs_pkg::OP_STSW;
        else if (keys_s.resume_key)              key_op = cmfs_pkg::OP_RESUME;
    end

    assign key_any   = |keys_s;
    assign pwr_rise  = pwr_s && !pwr_d_r;
    // power-on clear bypasses the run and tape gating
    assign start     = (st_r == cmfs_pkg::CH_IDLE) &&
                       (pwr_rise || (key_any && armed_r && !active && !tape_s));
    assign step_done = (tmr_r == STEP_CYC - 1'b1);
    assign p0        = start;
    assign p1        = (st_r == cmfs_pkg::CH_S1) && step_done;
    assign p2        = (st_r == cmfs_pkg::CH_S2) && step_done;

    // ************************************************************
    // manual timing chain
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= cmfs_pkg::CH_IDLE;
            tmr_r    <= '0;
            op_r     <= cmfs_pkg::OP_NONE;
            pwr_op_r <= 1'b0;
            pwr_d_r  <= 1'b0;
            armed_r  <= 1'b0;
            chain    <= '0;
        end else begin
            pwr_d_r <= pwr_s;
            chain.manual_pulse_first  <= p0;
            chain.manual_pulse_second <= p1;
            chain.manual_pulse_third  <= p2;
            // re-arm only after a release, so a held key cannot restart
            if (start)
                armed_r <= 1'b0;
            else if (!key_any)
                armed_r <= 1'b1;
            if (start && !pwr_rise)
                chain.key_held_level <= 1'b1;
            else if (!key_any)
                chain.key_held_level <= 1'b0;
            unique case (st_r)
                cmfs_pkg::CH_IDLE: begin
                    tmr_r <= '0;
                    if (start) begin
                        st_r     <= cmfs_pkg::CH_S1;
                        op_r     <= pwr_rise ? cmfs_pkg::OP_INIT : key_op;
                        pwr_op_r <= pwr_rise;
                        chain.manual_state_first <= 1'b1;
                    end
                end
                cmfs_pkg::CH_S1: begin
                    tmr_r <= step_done ? '0 : tmr_r + 1'b1;
                    if (step_done) begin
                        st_r <= cmfs_pkg::CH_S2;
                        chain.manual_state_first  <= 1'b0;
                        chain.manual_state_second <= 1'b1;
                    end
                end
                cmfs_pkg::CH_S2: begin
                    tmr_r <= step_done ? '0 : tmr_r + 1'b1;
                    if (step_done) begin
                        st_r <= cmfs_pkg::CH_WAIT;
                        chain.manual_state_second <= 1'b0;
                    end
                end
                cmfs_pkg::CH_WAIT: begin
                    tmr_r <= '0;
                    if (!key_any)
                        st_r <= cmfs_pkg::CH_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // clear pulses toward processor and peripherals
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clears <= '0;
        end else begin
            clears.skip_clear   <= p0 && (pwr_rise || key_op != cmfs_pkg::OP_RESUME);
            clears.half_clear   <= p0 && (pwr_rise || key_op != cmfs_pkg::OP_RESUME);
            clears.major_clear  <= p0 && (pwr_rise || key_op != cmfs_pkg::OP_RESUME);
            clears.cpu_clear    <= p1 && (op_r == cmfs_pkg::OP_INIT);
            clears.periph_clear <= p1 && (op_r == cmfs_pkg::OP_INIT);
        end
    end

    // ************************************************************
    // run, cycle and manual-op flags
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active           <= 1'b0;
            cycle_done       <= 1'b0;
            cycle_start      <= 1'b0;
            next_instr_gate  <= 1'b1;
            fetch_set        <= 1'b0;
            auto_repeat      <= 1'b0;
            deposit_adv_flag <= 1'b0;
            inspect_adv_flag <= 1'b0;
            manual_r         <= 1'b0;
            carry_ins_r      <= 1'b0;
        end else begin
            fetch_set   <= 1'b0;
            // cycle begins on all three flags; cycle-complete drops as it does
            cycle_start <= active && cycle_done && mem_idle && !cycle_start;
            if (active && cycle_done && mem_idle && !cycle_start)
                cycle_done <= 1'b0;
            if (p1 && op_r == cmfs_pkg::OP_INIT) begin
                active           <= 1'b0;
                auto_repeat      <= 1'b0;
                deposit_adv_flag <= 1'b0;
                inspect_adv_flag <= 1'b0;
                manual_r         <= 1'b0;
            end
            if (p1 && (op_r == cmfs_pkg::OP_DEPADV || op_r == cmfs_pkg::OP_INSPADV)
                    && auto_s && chain.key_held_level)
                auto_repeat <= 1'b1;
            if (p1 && op_r == cmfs_pkg::OP_DEPADV)
                deposit_adv_flag <= 1'b1;
            if (p1 && op_r == cmfs_pkg::OP_INSPADV)
                inspect_adv_flag <= 1'b1;
            if (p2 && op_r != cmfs_pkg::OP_INIT) begin
                active     <= 1'b1;
                cycle_done <= 1'b1;
                unique case (op_r)
                    cmfs_pkg::OP_DEP, cmfs_pkg::OP_INSP, cmfs_pkg::OP_DEPADV: begin
                        next_instr_gate <= 1'b0;
                        manual_r        <= 1'b1;
                    end
                    cmfs_pkg::OP_INSPADV: begin
                        next_instr_gate <= 1'b0;
                        manual_r        <= 1'b1;
                        carry_ins_r     <= 1'b1;
                    end
                    cmfs_pkg::OP_ST20, cmfs_pkg::OP_ST400, cmfs_pkg::OP_STSW: begin
                        next_instr_gate <= 1'b1;
                        fetch_set       <= 1'b1;
                    end
                    default: next_instr_gate <= 1'b1;
                endcase
            end
            if (tp1 && carry_ins_r)
                carry_ins_r <= 1'b0;
            // end of a manual memory cycle at time pulse 5
            if (tp5 && manual_r) begin
                if (deposit_adv_flag && !chain.key_held_level) begin
                    deposit_adv_flag <= 1'b0;
                    inspect_adv_flag <= 1'b1;
                    carry_ins_r      <= 1'b1;
                    cycle_done       <= 1'b1;
                end else begin
                    active           <= 1'b0;
                    auto_repeat      <= 1'b0;
                    inspect_adv_flag <= 1'b0;
                    deposit_adv_flag <= 1'b0;
                    manual_r         <= 1'b0;
                    next_instr_gate  <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // address, counter, buffer and opcode registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_addr_reg       <= cmfs_pkg::WORD_RESET;
            memory_buffer_reg  <= cmfs_pkg::WORD_RESET;
            opcode_holding_reg <= cmfs_pkg::WORD_RESET;
            prog_counter       <= cmfs_pkg::WORD_RESET;
            mem_write          <= 1'b0;
        end else begin
            mem_write <= 1'b0;
            if (p1) begin
                unique case (op_r)
                    cmfs_pkg::OP_INIT: begin
                        mem_addr_reg      <= cmfs_pkg::WORD_RESET;
                        memory_buffer_reg <= cmfs_pkg::WORD_RESET;
                        prog_counter      <= cmfs_pkg::WORD_RESET;
                        // opcode kept, only its top bits forced
                        opcode_holding_reg[11:9] <= cmfs_pkg::OPC_TOP_FORCE;
                    end
                    cmfs_pkg::OP_ST20:  prog_counter <= cmfs_pkg::START20_ADDR;
                    cmfs_pkg::OP_ST400: prog_counter <= cmfs_pkg::START400_ADDR;
                    cmfs_pkg::OP_STSW:  prog_counter <= lsw_s;
                    default: ;
                endcase
            end else if (p2) begin
                unique case (op_r)
                    cmfs_pkg::OP_DEP, cmfs_pkg::OP_INSP: mem_addr_reg <= lsw_s;
                    cmfs_pkg::OP_DEPADV: mem_addr_reg <= mem_addr_reg;
                    cmfs_pkg::OP_ST20, cmfs_pkg::OP_ST400, cmfs_pkg::OP_STSW:
                        mem_addr_reg <= prog_counter;
                    default: ;
                endcase
            end else if (tp1 && carry_ins_r) begin
                mem_addr_reg <= mem_addr_reg + 12'h001;
            end
            if (tp2 && !defer_state && !execute_state && !execute2_state)
                opcode_holding_reg <= cmfs_pkg::WORD_RESET;
            if (tp3 && manual_r) begin
                if (inspect_adv_flag || (!deposit_adv_flag && op_r == cmfs_pkg::OP_INSP)) begin
                    memory_buffer_reg <= mem_data;
                end else begin
                    memory_buffer_reg <= rsw_s;
                    mem_write         <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // mode and memory field registers
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg           <= cmfs_pkg::MODE_BASIC;
            instr_buffer_field <= '0;
            instr_field_reg    <= '0;
            data_field_reg     <= '0;
            save_field_reg     <= '0;
        end else begin
            if (p1 && op_r == cmfs_pkg::OP_INIT) begin
                instr_buffer_field <= '0;
                instr_field_reg    <= '0;
                data_field_reg     <= '0;
                save_field_reg     <= '0;
            end
            if (p2 && op_r == cmfs_pkg::OP_INIT) begin
                // power-on always lands in basic mode
                mode_reg           <= pwr_op_r ? cmfs_pkg::MODE_BASIC : mode_s;
                instr_buffer_field <= instr_buffer_field | cmfs_pkg::INSTR_FIELD_PRESET;
                instr_field_reg    <= instr_field_reg | cmfs_pkg::INSTR_FIELD_PRESET;
                data_field_reg     <= data_field_reg | cmfs_pkg::DATA_FIELD_PRESET;
                save_field_reg     <= save_field_reg | cmfs_pkg::SAVE_FIELD_PRESET;
            end
            if (p1 && op_r == cmfs_pkg::OP_STSW) begin
                instr_buffer_field[2:1] <= lsw_s[11:10];
                instr_field_reg[2:1]    <= lsw_s[11:10];
                if (ext_s)
                    instr_buffer_field[5:3] <= fsw_s;
            end
        end
    end

endmodule : cmfs_sequencer

// ==== verif/cmfs_props.sv ====
// checker for the console manual sequencer, on top-level ports only
// assumes one clock domain; switches stay steady while a chain runs
`timescale 1ns/100ps
module cmfs_props (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire cmfs_pkg::cmfs_keys_t  keys,
    input wire logic [11:0]           left_switch_bank,
    input wire logic                  mem_idle,
    input wire logic                  tp5,
    input wire cmfs_pkg::cmfs_chain_t chain,
    input wire logic                  active,
    input wire logic                  cycle_done,
    input wire logic                  cycle_start,
    input wire logic                  next_instr_gate,
    input wire logic                  deposit_adv_flag,
    input wire logic [11:0]           mem_addr_reg
);
    // all checks on the one clock, quiet during reset
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_STEP_TWO: assert property (chain.manual_pulse_first |-> ##20 chain.manual_pulse_second)
        else $error("second pulse off time");
    AST_STEP_THREE: assert property (chain.manual_pulse_second |-> ##20 chain.manual_pulse_third)
        else $error("third pulse off time");
    AST_HELD: assert property (chain.manual_pulse_first |-> chain.key_held_level)
        else $error("held level missing");
    AST_RUN_SET: assert property (chain.manual_pulse_third && !keys.init_key |->
        ##[0:1] (active && cycle_done))
        else $error("run flags not set");
    AST_CYCLE_GO: assert property (cycle_start |-> $past(active && cycle_done && mem_idle))
        else $error("cycle began early");
    AST_FIRST_IDLE: assert property (chain.manual_pulse_first |-> !$past(active))
        else $error("chain started while running");
    AST_ADDR_LOAD: assert property (chain.manual_pulse_third && keys.deposit_key |-> ##[0:1]
        mem_addr_reg == left_switch_bank)
        else $error("address not loaded");
    // halt only for manual memory ops, which hold the next-instruction gate shut
    AST_HALT: assert property (tp5 && active && !next_instr_gate && !deposit_adv_flag |=> !active)
        else $error("no halt at pulse five");
    cover property (chain.manual_pulse_third);
    cover property (cycle_start);
    cover property (tp5 && active && !next_instr_gate);
endmodule : cmfs_props
bind cmfs_sequencer cmfs_props props_u (.*);

// ==== verif/cmfs_operator.sv ====
// operator model: one debounced key and the two switch banks
// assumes the bench calls press() from a single process
`timescale 1ns/100ps
module cmfs_operator (
    input  wire logic            clk,
    output cmfs_pkg::cmfs_keys_t keys,
    output logic [11:0]          left_switch_bank,
    output logic [11:0]          right_switch_bank
);
    initial begin
        keys = '0;
        left_switch_bank = 12'h000;
        right_switch_bank = 12'h000;
    end
    // one key at a time, held well past the third pulse, then released
    task automatic press(input int k, input logic [11:0] l, input logic [11:0] r);
        @(negedge clk);
        left_switch_bank = l;
        right_switch_bank = r;
        keys = 9'h100 >> k;
        repeat (60) @(negedge clk);
        keys = '0;
        repeat (8) @(negedge clk);
    endtask : press
endmodule : cmfs_operator

// ==== verif/cmfs_sequencer_test.sv ====
// self-checking bench for the console manual sequencer
// assumes the operator model drives keys and switch banks
`timescale 1ns/100ps
module cmfs_sequencer_test;
    logic clk, rst_n, tape_busy, mode_switch, auto_switch, ext_mem_fitted, power_clear, tp1, tp2, tp3, tp5, mem_idle;
    logic defer_state, execute_state, execute2_state, active, cycle_done, cycle_start, next_instr_gate, fetch_set;
    logic mem_write, auto_repeat, deposit_adv_flag, inspect_adv_flag, mode_reg;
    logic [11:0] left_switch_bank, right_switch_bank, mem_data, mem_addr_reg, memory_buffer_reg;
    logic [11:0] opcode_holding_reg, prog_counter;
    logic [5:0]  instr_buffer_field, instr_field_reg, data_field_reg;
    logic [6:0]  save_field_reg;
    logic [2:0]  field_switches;
    cmfs_pkg::cmfs_keys_t   keys;
    cmfs_pkg::cmfs_chain_t  chain;
    cmfs_pkg::cmfs_clears_t clears;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    cmfs_operator op_u (.*);
    cmfs_sequencer dut_u (.*);
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // hang guard: nine key presses, eight of them running a chain, of about a hundred cycles each
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim
    task automatic restart();
        rst_n = 1'h0;
        repeat (5) @(negedge clk);
        rst_n = 1'h1;
        repeat (10) @(negedge clk);
    endtask : restart
    // one processor cycle, time pulses two clocks apart
    task automatic run_cycle();
        for (int i = 3; i >= 0; i--) begin
            @(negedge clk);
            {tp1, tp2, tp3, tp5} = 4'h1 << i;
            @(negedge clk);
            {tp1, tp2, tp3, tp5} = 4'h0;
        end
        repeat (2) @(negedge clk);
    endtask : run_cycle
    function automatic logic [11:0] exp_pc(int k, logic [11:0] l);
        return (k == 5) ? cmfs_pkg::START20_ADDR : (k == 6) ? cmfs_pkg::START400_ADDR : l;
    endfunction : exp_pc
    initial begin
        void'($urandom(32'h2bb2_d486));
        {rst_n, mode_switch, auto_switch, power_clear, tp1, tp2, tp3, tp5, defer_state} = '0;
        {execute_state, execute2_state, field_switches, mem_data} = '0;
        {ext_mem_fitted, mem_idle, tape_busy} = 3'h7;
        // a key during a tape transfer is ignored
        restart();
        op_u.press(1, 12'h0a5, 12'h05a);
        chk("tape_refuse", 12'h000, {11'h000, active});
        tape_busy = 1'h0;
        for (int k = 0; k < 8; k++) begin
            mem_data = 12'($urandom);
            mode_switch = 1'($urandom);
            restart();
            op_u.press(k, 12'($urandom), 12'($urandom));
            if (k == 0) begin
                chk("opcode_top", 12'h007, {9'h000, opcode_holding_reg[11:9]});
                chk("mode", {11'h000, mode_switch}, {11'h000, mode_reg});
                chk("data_field", {6'h00, cmfs_pkg::DATA_FIELD_PRESET}, {6'h00, data_field_reg});
                chk("init_idle", 12'h000, {11'h000, active});
                // no defer or execute state, so time pulse 2 wipes the opcode
                run_cycle();
                chk("opcode_clr", 12'h000, opcode_holding_reg);
            end else if (k < 5) begin
                if (k < 3)
                    chk("addr", left_switch_bank, mem_addr_reg);
                run_cycle();
                // deposit-advance released: a second, inspecting cycle follows
                if (k == 3) begin
                    chk("dep_buffer", right_switch_bank, memory_buffer_reg);
                    run_cycle();
                end
                if (k > 2)
                    chk("step_addr", 12'h001, mem_addr_reg);
                chk("buffer", (k == 1) ? right_switch_bank : mem_data, memory_buffer_reg);
                chk("halt", 12'h000, {11'h000, active});
            end else if (k > 4) begin
                chk("counter", exp_pc(k, left_switch_bank), prog_counter);
                chk("addr_start", exp_pc(k, left_switch_bank), mem_addr_reg);
            end
        end
        end_sim();
    end
endmodule : cmfs_sequencer_test
